// >>> hw/txe_line_enc.sv
/*
 * line encoder: four-symbol look-ahead pipeline producing unipolar,
 * AMI or HDB3 rail levels, one symbol per line bit tick.
 * assumes tick is a one-cycle pulse on the system clock.
 */
`timescale 1ns/10ps
`default_nettype none
module txe_line_enc (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              tick,
    input  wire txe_pkg::txe_sym_t sym_in,
    input  wire logic              unipolar,
    input  wire logic              ami,
    output logic                   pos_rail,
    output logic                   neg_rail
);
    localparam int LA = txe_pkg::LOOKAHEAD;

    txe_pkg::txe_sym_t pipe      [LA];
    txe_pkg::txe_sym_t next_pipe [LA];
    logic              [LA-1:0] zero;
    logic              last_pol;
    logic              parity;
    logic              next_last_pol;
    logic              next_parity;
    logic              next_pos;
    logic              next_neg;
    logic              head_mark;
    logic              head_pol;
    logic              subst;
    txe_pkg::txe_sym_t head;

    // ----------------------------------------------------------------
    // look-ahead pipeline
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < LA; g++) begin : g_pipe
            assign zero[g] = ~pipe[g].d & ~pipe[g].v;
            if (g == 0) begin : g_in
                assign next_pipe[g] = tick ? sym_in : pipe[g];
            end else if (g == 1) begin : g_mark
                // the fourth zero of a run becomes the violation
                always_comb begin
                    next_pipe[g] = tick ? pipe[g-1] : pipe[g];
                    if (tick && subst) begin
                        next_pipe[g].v = 1'b1;
                    end
                end
            end else begin : g_shift
                assign next_pipe[g] = tick ? pipe[g-1] : pipe[g];
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // symbol to rails
    // ----------------------------------------------------------------
    always_comb begin
        head      = pipe[LA-1];
        subst     = ~unipolar & ~ami & (&zero);
        // B of B00V only when pulses since the last V are even
        head_mark = head.d | head.v | (subst & ~parity);
        head_pol  = head.v ? last_pol : ~last_pol;
        next_last_pol = last_pol;
        next_parity   = parity;
        next_pos      = pos_rail;
        next_neg      = neg_rail;
        if (tick) begin
            if (unipolar) begin
                next_pos = head.d;
                next_neg = head.st;
            end else begin
                next_pos = head_mark & head_pol;
                next_neg = head_mark & ~head_pol;
                if (head_mark) begin
                    next_last_pol = head_pol;
                    next_parity   = head.v ? 1'b0 : ~parity;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < LA; i++) begin
                pipe[i] <= txe_pkg::SYM_IDLE;
            end
            last_pol <= 1'b0;
            parity   <= 1'b0;
            pos_rail <= 1'b0;
            neg_rail <= 1'b0;
        end else if (ce) begin
            pipe     <= next_pipe;
            last_pol <= next_last_pol;
            parity   <= next_parity;
            pos_rail <= next_pos;
            neg_rail <= next_neg;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_bip_tick;
        ce && tick && !unipolar;
    endsequence

    a_uni_data: assert property (@(posedge clk) disable iff (rst)
        ce && tick && unipolar |=> pos_rail == $past(head.d))
        else $error("unipolar data rail wrong");
    a_uni_frame: assert property (@(posedge clk) disable iff (rst)
        ce && tick && unipolar |=> neg_rail == $past(head.st))
        else $error("unipolar frame mark wrong");
    a_rails_excl: assert property (@(posedge clk) disable iff (rst)
        s_bip_tick |=> !(pos_rail && neg_rail))
        else $error("both rails high in bipolar mode");
    a_ami_alt: assert property (@(posedge clk) disable iff (rst)
        s_bip_tick ##0 (ami && head.d) |=> (pos_rail == !$past(last_pol)) && (pos_rail != neg_rail))
        else $error("mark did not alternate polarity");
    a_space_quiet: assert property (@(posedge clk) disable iff (rst)
        s_bip_tick ##0 (zero[LA-1] && !subst) |=> !pos_rail && !neg_rail)
        else $error("pulse sent for a space");
    a_hdb3_bpulse: assert property (@(posedge clk) disable iff (rst)
        s_bip_tick ##0 (subst && !parity) |=> pos_rail || neg_rail)
        else $error("missing B pulse of B00V");
    a_hdb3_viol: assert property (@(posedge clk) disable iff (rst)
        s_bip_tick ##0 head.v |=> (pos_rail == $past(last_pol)) && (pos_rail != neg_rail))
        else $error("violation pulse has wrong polarity");
endmodule
`default_nettype wire

// >>> hw/txe_pkg.sv
/*
 * constants, register indexes and carrier types for the transmit trace
 * inserter and line output block.
 * assumes nothing of its surroundings.
 */
`default_nettype none
package txe_pkg;
    // ----------------------------------------------------------------
    // register map (index; byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int          APB_AW          = 12;
    localparam logic [9:0]  IDX_IO_CTRL     = 10'h001;
    localparam logic [9:0]  IDX_TRACE_FIRST = 10'h038;
    localparam logic [9:0]  IDX_TRACE_SECOND = 10'h039;
    localparam logic [9:0]  IDX_TRACE_LAST  = 10'h047;
    localparam logic [9:0]  IDX_STATUS      = 10'h050;
    localparam logic [1:0]  ADDR_ALIGN      = 2'h0;

    // ----------------------------------------------------------------
    // line_io_control fields
    // ----------------------------------------------------------------
    localparam logic [7:0]  IO_CTRL_RST     = 8'hA0;
    localparam logic [7:0]  IO_CTRL_WMASK   = 8'hBF;
    localparam int          BIT_EDGE_SEL    = 2;
    localparam int          BIT_UNIPOLAR    = 3;
    localparam int          BIT_AMI         = 4;

    // ----------------------------------------------------------------
    // trace super-frame
    // ----------------------------------------------------------------
    localparam int          TRACE_N         = 16;
    localparam logic [7:0]  TRACE_RST       = 8'h00;
    localparam logic [3:0]  TRACE_POS_FIRST = 4'h0;
    localparam logic [3:0]  TRACE_POS_LAST  = 4'hF;
    localparam logic [3:0]  TRACE_POS_STEP  = 4'h1;
    localparam logic [2:0]  TR_BIT_FIRST    = 3'h0;
    localparam logic [2:0]  TR_BIT_MSB      = 3'h7;
    localparam logic [2:0]  TR_BIT_STEP     = 3'h1;

    // ----------------------------------------------------------------
    // encoder
    // ----------------------------------------------------------------
    localparam int          LOOKAHEAD       = 4;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic start;
        logic tr;
        logic data;
    } txe_frm_t;

    typedef struct packed {
        logic d;
        logic st;
        logic v;
    } txe_sym_t;

    localparam txe_sym_t    SYM_IDLE        = 3'h0;
endpackage
`default_nettype wire

// >>> hw/txe_trace_line_top.sv
/*
 * transmit trace identifier inserter and transmit line output with an
 * APB register slave.
 * assumes the framer datapath runs on CLK_SYS, holds FRM_IN for the
 * current line bit and moves on after each BIT_REQ pulse; the line
 * reference clock arrives from outside and is synchronised here.
 */
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module txe_trace_line_top (
    input  wire logic                        CLK_SYS,
    input  wire logic                        RST,
    input  wire logic                        CE,
    input  wire logic                        PSEL,
    input  wire logic                        PENABLE,
    input  wire logic                        PWRITE,
    input  wire logic [txe_pkg::APB_AW-1:0]  PADDR,
    input  wire logic [31:0]                 PWDATA,
    input  wire logic [3:0]                  PSTRB,
    output logic      [31:0]                 PRDATA,
    output logic                             PREADY,
    output logic                             PSLVERR,
    input  wire logic                        LINE_REF_CLK,
    input  wire txe_pkg::txe_frm_t           FRM_IN,
    output logic                             BIT_REQ,
    output logic      [7:0]                  TRACE_BYTE_FIELD,
    output logic                             LINE_CLOCK_OUT,
    output logic                             POS_RAIL_OUT,
    output logic                             NEG_RAIL_OUT
);
    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [7:0]  trace_id_byte      [txe_pkg::TRACE_N];
    logic [7:0]  next_trace_id_byte [txe_pkg::TRACE_N];
    logic [7:0]  line_io_control;
    logic [7:0]  next_line_io_control;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [9:0]  idx;
    logic [9:0]  trace_off;
    logic        is_trace;
    logic        mapped;
    logic        setup;
    logic        wr_take;
    logic [7:0]  status;

    // ----------------------------------------------------------------
    // line clock sampling and trace position state
    // ----------------------------------------------------------------
    logic        ref_s1;
    logic        ref_s2;
    logic        ref_s3;
    logic        tick;
    logic [3:0]  trace_pos;
    logic [3:0]  next_trace_pos;
    logic [2:0]  tr_bit;
    logic [2:0]  next_tr_bit;
    logic [7:0]  next_trace_byte;
    logic        line_bit;
    logic        start_take;
    txe_pkg::txe_sym_t enc_in;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    always_comb begin
        idx       = PADDR[txe_pkg::APB_AW-1:2];
        trace_off = idx - txe_pkg::IDX_TRACE_FIRST;
        is_trace  = (idx >= txe_pkg::IDX_TRACE_FIRST) && (idx <= txe_pkg::IDX_TRACE_LAST);
        mapped    = (PADDR[1:0] == txe_pkg::ADDR_ALIGN)
                    && (is_trace || idx == txe_pkg::IDX_IO_CTRL || idx == txe_pkg::IDX_STATUS);
        setup     = PSEL && !PENABLE;
        wr_take   = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && PSTRB[0];
        status    = {2'h0, POS_RAIL_OUT, NEG_RAIL_OUT, trace_pos};
        next_pready  = setup;
        next_pslverr = setup && !mapped;
        next_prdata  = '0;
        if (setup && !PWRITE && mapped) begin
            if (is_trace) begin
                next_prdata[7:0] = trace_id_byte[trace_off[3:0]];
            end else if (idx == txe_pkg::IDX_IO_CTRL) begin
                next_prdata[7:0] = line_io_control & txe_pkg::IO_CTRL_WMASK;
            end else begin
                next_prdata[7:0] = status;
            end
        end
        next_line_io_control = line_io_control;
        for (int i = 0; i < txe_pkg::TRACE_N; i++) begin
            next_trace_id_byte[i] = trace_id_byte[i];
        end
        if (wr_take && is_trace) begin
            next_trace_id_byte[trace_off[3:0]] = PWDATA[7:0];
        end
        if (wr_take && idx == txe_pkg::IDX_IO_CTRL) begin
            next_line_io_control = PWDATA[7:0] & txe_pkg::IO_CTRL_WMASK;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            for (int i = 0; i < txe_pkg::TRACE_N; i++) begin
                trace_id_byte[i] <= txe_pkg::TRACE_RST;
            end
            line_io_control <= txe_pkg::IO_CTRL_RST;
            PRDATA          <= '0;
            PREADY          <= 1'b0;
            PSLVERR         <= 1'b0;
        end else if (CE) begin
            trace_id_byte   <= next_trace_id_byte;
            line_io_control <= next_line_io_control;
            PRDATA          <= next_prdata;
            PREADY          <= next_pready;
            PSLVERR         <= next_pslverr;
        end
    end

    // ----------------------------------------------------------------
    // line clock: synchronise, find the selected edge, echo it out
    // ----------------------------------------------------------------
    always_comb begin
        tick = line_io_control[txe_pkg::BIT_EDGE_SEL] ? (!ref_s2 && ref_s3)
                                                      : (ref_s2 && !ref_s3);
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ref_s1         <= 1'b0;
            ref_s2         <= 1'b0;
            ref_s3         <= 1'b0;
            LINE_CLOCK_OUT <= 1'b0;
            BIT_REQ        <= 1'b0;
        end else if (CE) begin
            ref_s1         <= LINE_REF_CLK;
            ref_s2         <= ref_s1;
            ref_s3         <= ref_s2;
            LINE_CLOCK_OUT <= ref_s2;
            BIT_REQ        <= tick;
        end
    end

    // ----------------------------------------------------------------
    // trace byte insertion
    // ----------------------------------------------------------------
    always_comb begin
        start_take      = tick && FRM_IN.start;
        next_trace_pos  = trace_pos;
        next_trace_byte = TRACE_BYTE_FIELD;
        next_tr_bit     = tr_bit;
        if (start_take) begin
            next_trace_byte = trace_id_byte[trace_pos];
            next_tr_bit     = txe_pkg::TR_BIT_FIRST;
            if (trace_pos == txe_pkg::TRACE_POS_LAST) begin
                next_trace_pos = txe_pkg::TRACE_POS_FIRST;
            end else begin
                next_trace_pos = trace_pos + txe_pkg::TRACE_POS_STEP;
            end
        end else if (tick && FRM_IN.tr) begin
            next_tr_bit = tr_bit + txe_pkg::TR_BIT_STEP;
        end
        // trace byte goes out most significant bit first
        line_bit = FRM_IN.tr ? TRACE_BYTE_FIELD[txe_pkg::TR_BIT_MSB - tr_bit]
                             : FRM_IN.data;
        enc_in   = '{d: line_bit, st: FRM_IN.start, v: 1'b0};
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            trace_pos        <= txe_pkg::TRACE_POS_FIRST;
            TRACE_BYTE_FIELD <= txe_pkg::TRACE_RST;
            tr_bit           <= txe_pkg::TR_BIT_FIRST;
        end else if (CE) begin
            trace_pos        <= next_trace_pos;
            TRACE_BYTE_FIELD <= next_trace_byte;
            tr_bit           <= next_tr_bit;
        end
    end

    // ----------------------------------------------------------------
    // line encoder
    // ----------------------------------------------------------------
    txe_line_enc u_enc (
        .clk      (CLK_SYS),
        .rst      (RST),
        .ce       (CE),
        .tick     (tick),
        .sym_in   (enc_in),
        .unipolar (line_io_control[txe_pkg::BIT_UNIPOLAR]),
        .ami      (line_io_control[txe_pkg::BIT_AMI]),
        .pos_rail (POS_RAIL_OUT),
        .neg_rail (NEG_RAIL_OUT)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_first_byte: assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && start_take && trace_pos == txe_pkg::TRACE_POS_FIRST
        |=> TRACE_BYTE_FIELD == $past(trace_id_byte[0]))
        else $error("first frame did not take first trace byte");
    a_second_byte: assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && start_take && trace_pos == txe_pkg::TRACE_POS_STEP
        |=> TRACE_BYTE_FIELD == $past(trace_id_byte[1]))
        else $error("second frame did not take second trace byte");
    a_pos_advance: assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && start_take && trace_pos != txe_pkg::TRACE_POS_LAST
        |=> trace_pos == $past(trace_pos) + 4'h1)
        else $error("trace position did not advance");
    a_pos_wrap: assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && start_take && trace_pos == txe_pkg::TRACE_POS_LAST |=> trace_pos == 4'h0)
        else $error("trace position did not wrap");
    a_pos_reset: assert property (@(posedge CLK_SYS)
        RST |=> trace_pos == 4'h0)
        else $error("trace position not cleared by reset");
    a_tr_bit_sel: assert property (@(posedge CLK_SYS) disable iff (RST)
        FRM_IN.tr |-> enc_in.d == TRACE_BYTE_FIELD[3'h7 - tr_bit])
        else $error("wrong trace bit sent");
    a_clk_echo: assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && $past(CE) |-> ##1 LINE_CLOCK_OUT == $past(ref_s2))
        else $error("line clock output not following reference");
    a_rail_edge: assert property (@(posedge CLK_SYS) disable iff (RST)
        $changed(POS_RAIL_OUT) || $changed(NEG_RAIL_OUT) |-> $past(tick))
        else $error("rail changed away from the selected edge");
    a_apb_answer: assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && PSEL && !PENABLE |=> PREADY ##1 (!PREADY || !CE))
        else $error("apb answer not one cycle");
endmodule
`default_nettype wire

// >>> verif/txe_line_unit.sv
/*
 * behavioural line interface unit: makes the line reference clock and
 * samples both rails on the line clock output.
 * assumes bipolar is high only while a bipolar code is selected.
 */
`timescale 1ns/10ps
`default_nettype none
module txe_line_unit (
    output logic       ref_clk,
    input  wire logic  run,
    input  wire logic  line_clk,
    input  wire logic  pos,
    input  wire logic  neg,
    input  wire logic  bipolar,
    input  wire logic  upd_fall,
    output logic [7:0] clash_cnt
);
    initial ref_clk = 1'b0;
    initial clash_cnt = 8'h00;
    // 160 ns reference while bits stream, parked low otherwise
    always #80 ref_clk = run & ~ref_clk;
    // sample on the edge opposite to the one that moves the rails
    always @(line_clk) begin
        if (line_clk == upd_fall && bipolar && pos && neg) begin
            clash_cnt <= clash_cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// >>> verif/txe_trace_line_top_tb.sv
/*
 * self-checking bench: APB register checks and a bit-level framer and
 * line code model compared at every taken bit, in all output modes.
 * assumes the design and its package are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module txe_trace_line_top_tb;
    logic              CLK_SYS = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0]       PADDR = 12'h000;
    logic [31:0]       PWDATA = 32'h0, PRDATA;
    logic [3:0]        PSTRB = 4'h0;
    logic              PREADY, PSLVERR, REF_CLK, BIT_REQ, LCLK, POS, NEG;
    logic [7:0]        TBF, clash_cnt, rd, mode = 8'hA0;
    logic              er, run = 1'b0;
    txe_pkg::txe_frm_t frm = 3'h4;
    logic [7:0]        tr_reg [16];
    logic [7:0]        modes [4] = '{8'hE0, 8'hB0, 8'hA8, 8'hE4};
    int                num_errors = 0, num_checks = 0, lastp, npar, zrun, i;
    int                q [$];

    always #4 CLK_SYS = ~CLK_SYS;

    txe_trace_line_top dut_u (.CLK_SYS(CLK_SYS), .RST(RST), .CE(1'b1), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LINE_REF_CLK(REF_CLK),
        .FRM_IN(frm), .BIT_REQ(BIT_REQ), .TRACE_BYTE_FIELD(TBF), .LINE_CLOCK_OUT(LCLK),
        .POS_RAIL_OUT(POS), .NEG_RAIL_OUT(NEG));
    txe_line_unit lu_u (.ref_clk(REF_CLK), .run(run), .line_clk(LCLK), .pos(POS), .neg(NEG),
        .bipolar(~mode[3]), .upd_fall(mode[2]), .clash_cnt(clash_cnt));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= {24'h000000, d};
        PSTRB <= 4'hF;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do @(posedge CLK_SYS); while (PREADY !== 1'b1);
        rd = PRDATA[7:0];
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    // line code model: four-bit look-ahead, rails coded {neg,pos}
    task automatic push(input logic bt, input logic st, output logic [1:0] e);
        if (mode[3]) q.push_back({st, bt});
        else if (bt) begin
            lastp = -lastp;
            q.push_back(lastp > 0 ? 1 : 2);
            npar ^= 1;
            zrun = 0;
        end else begin
            zrun++;
            q.push_back(0);
            if (!mode[4] && zrun == 4) begin
                if (npar == 0) begin
                    lastp = -lastp;
                    q[q.size()-4] = lastp > 0 ? 1 : 2;
                end
                q[q.size()-1] = lastp > 0 ? 1 : 2;
                npar = 0;
                zrun = 0;
            end
        end
        e = q.size() > 4 ? 2'(q.pop_front()) : 2'h0;
    endtask

    task automatic run_mode(input logic [7:0] m);
        int f, b, n;
        logic bt;
        logic [1:0] e;
        @(posedge CLK_SYS);
        RST <= 1'b1;
        run <= 1'b0;
        frm <= 3'h4;
        // the parked reference settles while reset holds the synchroniser
        repeat (16) @(posedge CLK_SYS);
        RST <= 1'b0;
        lastp = -1;
        npar = 0;
        zrun = 0;
        q.delete();
        apb(1'b1, {txe_pkg::IDX_IO_CTRL, 2'h0}, m);
        apb(1'b0, {txe_pkg::IDX_IO_CTRL, 2'h0}, 8'h00);
        chk("io_ctrl", m & txe_pkg::IO_CTRL_WMASK, rd);
        mode = m;
        // after reset the encoder pipeline holds four spaces
        repeat (4) push(1'b0, 1'b0, e);
        for (n = 0; n < 16; n++) begin
            tr_reg[n] = (n == 0) ? 8'(8'h80 | $urandom) : 8'($urandom & 8'h7F);
            apb(1'b1, {txe_pkg::IDX_TRACE_FIRST + 10'(n), 2'h0}, tr_reg[n]);
        end
        for (n = 0; n < 16; n++) begin
            apb(1'b0, {txe_pkg::IDX_TRACE_FIRST + 10'(n), 2'h0}, 8'h00);
            chk("trace_reg", tr_reg[n], rd);
        end
        run <= 1'b1;
        for (f = 0; f < 17; f++) begin
            for (b = 0; b < 16; b++) begin
                do @(negedge CLK_SYS); while (BIT_REQ !== 1'b1);
                bt = frm.tr ? tr_reg[f % 16][8-b] : frm.data;
                if (b == 0) chk("trace_field", tr_reg[f % 16], TBF);
                push(bt, frm.start, e);
                chk("rails", {6'h00, e}, {6'h00, NEG, POS});
                chk("line_clk", {7'h00, ~m[2]}, {7'h00, LCLK});
                @(posedge CLK_SYS);
                frm <= '{start: (b == 15), tr: (b < 8), data: ($urandom % 4 == 0)};
            end
        end
        chk("clash", 8'h00, clash_cnt);
        $display("test mode %h done", m);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hC8664FEB));
        repeat (8) @(posedge CLK_SYS);
        RST <= 1'b0;
        apb(1'b0, {txe_pkg::IDX_IO_CTRL, 2'h0}, 8'h00);
        chk("io_ctrl_rst", txe_pkg::IO_CTRL_RST, rd);
        apb(1'b0, 12'h3FC, 8'h00);
        chk("unmapped_err", 8'h01, {7'h00, er});
        apb(1'b0, {txe_pkg::IDX_STATUS, 2'h0}, 8'h00);
        chk("status_rst", 8'h00, rd);
        $display("test registers done");
        for (i = 0; i < 4; i++) run_mode(modes[i]);
        close_out();
    end

    initial begin
        #400000;
        num_errors++;
        close_out();
    end
endmodule
`default_nettype wire
